// ---- common/oad_pkg.sv ----
`default_nettype none
package oad_pkg;
   localparam logic [7:0] PRE_SECOND_INDEX = 8'h90;
   localparam logic [7:0] PRE_INDIRECT = 8'h92;
   localparam logic [7:0] PRE_SECOND_INDIRECT = 8'h91;
   localparam int NUM_MODES = 17;
   localparam int NUM_GROUPS = 7;
   localparam logic [15:0] PAGE_ZERO_TOP = 16'h00ff;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_ADDR = 16'h0000;

   typedef enum logic [4:0] {
      OAD_INH = 5'h00, OAD_IMM = 5'h01, OAD_DIR_S = 5'h02, OAD_DIR_L = 5'h03,
      OAD_IDX_N = 5'h04, OAD_IDX_S = 5'h05, OAD_IDX_L = 5'h06, OAD_IND_S = 5'h07,
      OAD_IND_L = 5'h08, OAD_IIX_S = 5'h09, OAD_IIX_L = 5'h0a, OAD_REL_D = 5'h0b,
      OAD_REL_I = 5'h0c, OAD_BIT_D = 5'h0d, OAD_BIT_I = 5'h0e, OAD_BTJ_D = 5'h0f,
      OAD_BTJ_I = 5'h10
   } oad_mode_e;

   typedef enum logic [2:0] {
      ST_OPC = 3'b000, ST_OPND = 3'b001, ST_PTR = 3'b011, ST_DONE = 3'b010
   } oad_state_e;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } oad_byte_s;

   typedef struct packed {
      logic valid;
      oad_mode_e mode;
      logic use_y;
      logic rmw;
      logic [15:0] ea;
      logic [7:0] imm;
      logic [15:0] pc_target;
      logic [1:0] length;
      logic error;
   } oad_result_s;
endpackage
`default_nettype wire

// ---- src/oad_adder.sv ----
`default_nettype none
module oad_adder
   import oad_pkg::*;
(
   input wire logic [15:0] base_i,
   input wire logic [7:0] index_i,
   input wire logic signed_i,
   output logic [15:0] sum_o
);
   always_comb begin
      if (signed_i) begin
         sum_o = base_i + {{8{index_i[7]}}, index_i};
      end else begin
         sum_o = base_i + {8'h00, index_i};
      end
   end
endmodule
`default_nettype wire

// ---- src/oad_decoder.sv ----
`default_nettype none
// How it works
// - seventeen addressing modes in seven groups are decoded
// - inherent is one byte, no operand fetched
// - immediate takes one following byte as the operand value
// - short direct takes one address byte, range 00-FF
// - long direct takes a two-byte address, full 64 Kbyte
// - indexed address is unsigned sum of selected index and offset
// - no-offset indexed fetches nothing, uses index alone
// - short indexed adds one offset byte, reaching 1FE without wrap
// - long indexed adds a two-byte offset over 64 Kbyte
// - short indirect reads a byte pointer from a page-zero pointer address
// - long indirect reads a word pointer from a page-zero pointer address
// - relative targets are relative to the address after the branch
// - short forms reach page zero with fewer bytes
// - memory read-modify-write opcodes accept short forms only
// - long forms reach 64 Kbyte using extra bytes and cycles
// - indirect indexed adds the index to a pointer read from memory
// - relative adds a signed 8-bit offset, direct or from memory
// - prefix 90 selects second index, 92 indirect, 91 indirect second index
module oad_decoder
   import oad_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic [15:0] pc_i,
   input wire oad_byte_s prefix_i,
   input wire logic [7:0] opcode_i,
   input wire oad_mode_e mode_i,
   input wire logic rmw_i,
   input wire logic [7:0] x_i,
   input wire logic [7:0] y_i,
   input wire oad_byte_s fetch_i,
   output logic fetch_req_o,
   output logic fetch_data_o,
   output logic [15:0] fetch_addr_o,
   output oad_result_s result_o,
   output logic busy_o
);
   typedef struct packed {
      oad_state_e st;
      oad_mode_e mode;
      logic use_y;
      logic indir;
      logic rmw;
      logic [1:0] need;
      logic [1:0] ptr_need;
      logic [15:0] acc;
      logic [15:0] pc;
      logic [1:0] len;
      logic req;
      logic from_data;
      logic [15:0] faddr;
      logic err;
      logic busy;
      oad_result_s res;
   } oad_state_s;

   oad_state_s state_reg;
   oad_state_s state_next;
   logic [15:0] idx_sum;
   logic [15:0] rel_sum;
   logic [7:0] sel_index;
   logic [15:0] idx_base;
   logic [7:0] rel_off;

   assign sel_index = state_reg.use_y ? y_i : x_i;
   // indirect bit-test-jump: the pointer read pushed the offset into the high byte
   assign rel_off = (state_reg.mode == OAD_BTJ_I) ? state_reg.acc[15:8] : state_reg.acc[7:0];
   assign idx_base = (state_reg.mode == OAD_IDX_N) ? 16'h0000 : state_reg.acc;

   oad_adder u_index (
      .base_i(idx_base),
      .index_i(sel_index),
      .signed_i(1'b0),
      .sum_o(idx_sum)
   );

   oad_adder u_rel (
      .base_i(state_reg.pc),
      .index_i(rel_off),
      .signed_i(1'b1),
      .sum_o(rel_sum)
   );

   function automatic logic [1:0] opnd_bytes(input oad_mode_e m);
      unique case (m)
         OAD_INH, OAD_IDX_N: opnd_bytes = 2'd0;
         OAD_DIR_L, OAD_IDX_L, OAD_BTJ_D, OAD_BTJ_I: opnd_bytes = 2'd2;
         default: opnd_bytes = 2'd1;
      endcase
   endfunction

   function automatic logic [1:0] ptr_bytes(input oad_mode_e m);
      unique case (m)
         OAD_IND_L, OAD_IIX_L: ptr_bytes = 2'd2;
         OAD_IND_S, OAD_IIX_S, OAD_REL_I, OAD_BIT_I, OAD_BTJ_I: ptr_bytes = 2'd1;
         default: ptr_bytes = 2'd0;
      endcase
   endfunction

   function automatic logic is_long(input oad_mode_e m);
      is_long = (m == OAD_DIR_L) || (m == OAD_IDX_L) || (m == OAD_IND_L) || (m == OAD_IIX_L);
   endfunction

   always_comb begin
      oad_mode_e m;
      m = mode_i;
      state_next = state_reg;
      state_next.req = 1'b0;
      state_next.res.valid = 1'b0;
      unique case (state_reg.st)
         ST_OPC: begin
            if (start_i) begin
               m = mode_i;
               state_next.use_y = 1'b0;
               state_next.indir = 1'b0;
               if (prefix_i.valid) begin
                  unique case (prefix_i.data)
                     PRE_SECOND_INDEX: state_next.use_y = 1'b1;
                     PRE_INDIRECT: state_next.indir = 1'b1;
                     PRE_SECOND_INDIRECT: begin
                        state_next.use_y = 1'b1;
                        state_next.indir = 1'b1;
                     end
                     default: ;
                  endcase
                  if (state_next.indir) begin
                     unique case (mode_i)
                        OAD_DIR_S: m = OAD_IND_S;
                        OAD_DIR_L: m = OAD_IND_L;
                        OAD_IDX_S: m = OAD_IIX_S;
                        OAD_IDX_L: m = OAD_IIX_L;
                        OAD_REL_D: m = OAD_REL_I;
                        OAD_BIT_D: m = OAD_BIT_I;
                        OAD_BTJ_D: m = OAD_BTJ_I;
                        default: m = mode_i;
                     endcase
                  end
               end
               state_next.mode = m;
               state_next.rmw = rmw_i;
               state_next.need = opnd_bytes(m);
               // length counts stream bytes after the opcode; the prefix is not included
               state_next.len = opnd_bytes(m);
               state_next.ptr_need = ptr_bytes(m);
               state_next.acc = RESET_ADDR;
               state_next.pc = pc_i + 16'd1;
               // held aside so the previous result stays intact until the new one
               state_next.err = rmw_i && is_long(m);
               state_next.st = ST_OPND;
               if (opnd_bytes(m) != 2'd0) begin
                  state_next.req = 1'b1;
                  state_next.from_data = 1'b0;
                  state_next.faddr = pc_i + 16'd1;
               end
            end
         end
         ST_OPND: begin
            if (state_reg.need == 2'd0) begin
               state_next.st = (state_reg.ptr_need != 2'd0) ? ST_PTR : ST_DONE;
               if (state_reg.ptr_need != 2'd0) begin
                  state_next.req = 1'b1;
                  state_next.from_data = 1'b1;
                  state_next.faddr = {8'h00, state_reg.acc[7:0]};
                  state_next.acc = RESET_ADDR;
                  // bit-test-jump: pointer address came first, keep the offset byte
                  if (state_reg.mode == OAD_BTJ_I) begin
                     state_next.faddr = {8'h00, state_reg.acc[15:8]};
                     state_next.acc = {8'h00, state_reg.acc[7:0]};
                  end
               end
            end else if (fetch_i.valid) begin
               state_next.acc = {state_reg.acc[7:0], fetch_i.data};
               state_next.pc = state_reg.pc + 16'd1;
               state_next.need = state_reg.need - 2'd1;
               if (state_reg.need == 2'd2) begin
                  state_next.req = 1'b1;
                  state_next.faddr = state_reg.pc + 16'd1;
               end
            end
         end
         ST_PTR: begin
            if (fetch_i.valid) begin
               state_next.acc = {state_reg.acc[7:0], fetch_i.data};
               state_next.ptr_need = state_reg.ptr_need - 2'd1;
               if (state_reg.ptr_need == 2'd1) begin
                  state_next.st = ST_DONE;
               end else begin
                  state_next.req = 1'b1;
                  state_next.faddr = state_reg.faddr + 16'd1;
               end
            end
         end
         ST_DONE: begin
            state_next.st = ST_OPC;
            state_next.res.valid = 1'b1;
            state_next.res.mode = state_reg.mode;
            state_next.res.use_y = state_reg.use_y;
            state_next.res.rmw = state_reg.rmw;
            state_next.res.length = state_reg.len;
            state_next.res.error = state_reg.err;
            state_next.res.imm = state_reg.acc[7:0];
            state_next.res.pc_target = state_reg.pc;
            state_next.res.ea = state_reg.acc;
            unique case (state_reg.mode)
               OAD_IDX_N, OAD_IDX_S, OAD_IDX_L, OAD_IIX_S, OAD_IIX_L:
                  state_next.res.ea = idx_sum;
               OAD_DIR_S, OAD_IND_S, OAD_BIT_D, OAD_BIT_I:
                  state_next.res.ea = {8'h00, state_reg.acc[7:0]};
               OAD_REL_D, OAD_REL_I:
                  state_next.res.pc_target = rel_sum;
               OAD_BTJ_D: begin
                  state_next.res.ea = {8'h00, state_reg.acc[15:8]};
                  state_next.res.pc_target = rel_sum;
               end
               OAD_BTJ_I: begin
                  state_next.res.ea = {8'h00, state_reg.acc[7:0]};
                  state_next.res.pc_target = rel_sum;
               end
               default: ;
            endcase
         end
         default: state_next.st = ST_OPC;
      endcase
      state_next.busy = (state_next.st != ST_OPC);
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign fetch_req_o = state_reg.req;
   assign fetch_data_o = state_reg.from_data;
   assign fetch_addr_o = state_reg.faddr;
   assign result_o = state_reg.res;
   assign busy_o = state_reg.busy;
endmodule
`default_nettype wire

// ---- test/oad_dec_props.sv ----
`default_nettype none
module oad_dec_props
   import oad_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic [15:0] pc_i,
   input wire oad_byte_s prefix_i,
   input wire oad_mode_e mode_i,
   input wire logic [7:0] x_i,
   input wire logic fetch_req_o,
   input wire logic fetch_data_o,
   input wire logic [15:0] fetch_addr_o,
   input wire oad_result_s result_o,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // only unprefixed starts, though a prefix leaves the first stream fetch at pc_i + 1
   wire go = start_i && !busy_o && !prefix_i.valid;
   a_req_pulse: assert property (fetch_req_o |-> busy_o ##1 !fetch_req_o)
      else $error("fetch request stretched or idle");
   a_valid_end: assert property (result_o.valid |=> !result_o.valid && !busy_o)
      else $error("result pulse stretched");
   a_inh_nofetch: assert property (go && mode_i == OAD_INH |=> !fetch_req_o [*2])
      else $error("inherent fetched a byte");
   a_first_fetch: assert property (go && !(mode_i inside {OAD_INH, OAD_IDX_N}) |=>
      fetch_req_o && !fetch_data_o && fetch_addr_o == $past(pc_i) + 16'h1)
      else $error("first operand fetch wrong");
   a_short_page: assert property (result_o.valid && !result_o.error &&
      result_o.mode inside {OAD_DIR_S, OAD_IND_S, OAD_BIT_D, OAD_BIT_I, OAD_BTJ_D, OAD_BTJ_I}
      |-> result_o.ea[15:8] == 8'h00)
      else $error("short form left page zero");
   a_ptr_page: assert property (fetch_req_o && fetch_data_o |->
      fetch_addr_o[15:8] == 8'h00)
      else $error("pointer read outside page zero");
   a_idxn_ea: assert property (result_o.valid && result_o.mode == OAD_IDX_N &&
      !result_o.use_y |-> result_o.ea == {8'h00, x_i} && result_o.length == 2'd0)
      else $error("no-offset index address wrong");
   a_rmw_long: assert property (result_o.valid && result_o.rmw &&
      result_o.mode inside {OAD_DIR_L, OAD_IDX_L} |-> result_o.error)
      else $error("long form allowed for rmw");
   a_long_len: assert property (result_o.valid && !result_o.error &&
      result_o.mode inside {OAD_DIR_L, OAD_IDX_L} |-> result_o.length == 2'd2)
      else $error("long form length wrong");
endmodule
bind oad_decoder oad_dec_props oad_dec_props_inst(.clock_i, .nrst_i, .start_i, .pc_i,
   .prefix_i, .mode_i, .x_i, .fetch_req_o, .fetch_data_o, .fetch_addr_o, .result_o, .busy_o);
`default_nettype wire

// ---- test/oad_mem.sv ----
`default_nettype none
module oad_mem
   import oad_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [3:0] lat_i,
   input wire logic req_i,
   input wire logic [15:0] addr_i,
   output var oad_byte_s byte_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt;
   logic [7:0] d;
   // idle data toggles so a stale byte never looks like an answer
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {cnt, d, byte_o} <= '0;
      end else begin
         byte_o <= {1'b0, ~byte_o.data};
         if (req_i) begin
            cnt <= {1'b0, lat_i} + 5'd1;
            d <= addr_i[7:0] + 8'h11;
         end else if (cnt == 5'd1) begin
            byte_o <= {1'b1, d};
            cnt <= '0;
         end else if (cnt != 5'd0) cnt <= cnt - 5'd1;
      end
   end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`default_nettype none
module tb
   import oad_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] A = 16'h12ed, B = 16'h1200;
   logic clock_i = 0, nrst_i = 0, start_i = 0, rmw_i = 0, er_v = 0;
   logic fetch_req_o, fetch_data_o, busy_o;
   logic [15:0] pc_i = '0, fetch_addr_o;
   logic [7:0] opcode_i = 8'h5a, x_i = 8'hff, y_i = 8'h80;
   logic [3:0] lat = '0;
   oad_byte_s prefix_i = '0, fetch_i;
   oad_mode_e mode_i = OAD_INH;
   oad_result_s result_o;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   always #25 clock_i = ~clock_i;
   oad_decoder oad_decoder_inst(.clock_i, .nrst_i, .start_i, .pc_i, .prefix_i, .opcode_i,
      .mode_i, .rmw_i, .x_i, .y_i, .fetch_i, .fetch_req_o, .fetch_data_o, .fetch_addr_o,
      .result_o, .busy_o);
   oad_mem oad_mem_inst(.clock_i, .nrst_i, .lat_i(lat), .req_i(fetch_req_o),
      .addr_i(fetch_addr_o), .byte_o(fetch_i));
   task automatic cmp(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         num_errors++;
      end
   endtask
   task automatic run(input logic [7:0] pre, input oad_mode_e mi, mo, input logic [15:0] pc,
      input logic [1:0] ln, input logic [15:0] ea, tg);
      int n;
      @(posedge clock_i) #2;
      start_i = 1'b1;
      pc_i = pc;
      mode_i = mi;
      prefix_i = {pre != 8'h00, pre};
      @(posedge clock_i) #2;
      start_i = 0;
      for (n = 0; n < 40 && result_o.valid !== 1'b1; n++) @(posedge clock_i) #2;
      cmp(16'(n < 40), 16'h1);
      cmp(16'(result_o.error), 16'(er_v));
      if (!er_v) begin
         cmp(16'(result_o.length), 16'(ln));
         cmp(16'(result_o.mode), 16'(mo));
         cmp(16'(result_o.use_y), 16'(pre == 8'h90 || pre == 8'h91));
         if (mo == OAD_IMM) cmp(16'(result_o.imm), ea);
         else if (!(mo inside {OAD_INH, OAD_REL_D, OAD_REL_I})) cmp(result_o.ea, ea);
         if (mo inside {OAD_REL_D, OAD_REL_I, OAD_BTJ_D, OAD_BTJ_I}) begin
            cmp(result_o.pc_target, tg);
         end
      end
   endtask
   task automatic t_modes(input logic [3:0] l);
      lat = l;
      run(8'h00, OAD_INH, OAD_INH, A, 2'd0, '0, '0);
      run(8'h00, OAD_IMM, OAD_IMM, A, 2'd1, 16'h00ff, '0);
      run(8'h00, OAD_DIR_S, OAD_DIR_S, A, 2'd1, 16'h00ff, '0);
      run(8'h00, OAD_DIR_L, OAD_DIR_L, A, 2'd2, 16'hff00, '0);
      run(8'h00, OAD_IDX_N, OAD_IDX_N, A, 2'd0, 16'h00ff, '0);
      run(8'h90, OAD_IDX_N, OAD_IDX_N, A, 2'd0, 16'h0080, '0);
      run(8'h00, OAD_IDX_S, OAD_IDX_S, A, 2'd1, 16'h01fe, '0);
      run(8'h00, OAD_IDX_L, OAD_IDX_L, A, 2'd2, 16'hffff, '0);
      run(8'h92, OAD_DIR_S, OAD_IND_S, B, 2'd1, 16'h0023, '0);
      run(8'h92, OAD_DIR_L, OAD_IND_L, B, 2'd1, 16'h2324, '0);
      run(8'h92, OAD_IDX_S, OAD_IIX_S, B, 2'd1, 16'h0122, '0);
      run(8'h91, OAD_IDX_S, OAD_IIX_S, B, 2'd1, 16'h00a3, '0);
      run(8'h92, OAD_IDX_L, OAD_IIX_L, B, 2'd1, 16'h2423, '0);
      run(8'h00, OAD_REL_D, OAD_REL_D, A, 2'd1, '0, 16'h12ee);
      run(8'h92, OAD_REL_D, OAD_REL_I, B, 2'd1, '0, 16'h1225);
      run(8'h00, OAD_BIT_D, OAD_BIT_D, B, 2'd1, 16'h0012, '0);
      run(8'h92, OAD_BIT_D, OAD_BIT_I, B, 2'd1, 16'h0023, '0);
      run(8'h00, OAD_BTJ_D, OAD_BTJ_D, B, 2'd2, 16'h0012, 16'h1216);
      run(8'h92, OAD_BTJ_D, OAD_BTJ_I, B, 2'd2, 16'h0023, 16'h1216);
      $display("modes done, latency %0d", l);
   endtask
   task automatic t_rmw;
      rmw_i = 1;
      run(8'h00, OAD_DIR_S, OAD_DIR_S, A, 2'd1, 16'h00ff, '0);
      er_v = 1;
      run(8'h00, OAD_DIR_L, OAD_DIR_L, A, 2'd2, '0, '0);
      run(8'h00, OAD_IDX_L, OAD_IDX_L, A, 2'd2, '0, '0);
      {rmw_i, er_v} = 2'b00;
      $display("rmw done");
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock_i) if (++cyc == 4000) begin
      num_errors++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clock_i);
      #2;
      nrst_i = 1;
      t_modes(4'd0);
      t_modes(4'd3);
      t_rmw();
      print_verdict();
   end
endmodule
`default_nettype wire
